// File: rwc_pkg.sv
package rwc_pkg;

    // I/O port addresses
    localparam logic [7:0]  IO_STATUS_ADDR    = 8'hFF;
    localparam logic [7:0]  IO_WDT_CLEAR_ADDR = 8'h26;
    localparam logic [7:0]  IO_USB_ADDR_ADDR  = 8'h10;

    // Status and control register fields
    localparam int          STAT_POR_BIT      = 4;
    localparam int          STAT_USBR_BIT     = 5;
    localparam int          STAT_WDOG_BIT     = 6;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    localparam logic [7:0]  CAUSE_MASK        = 8'h70;

    // Values restored by a hardware reset
    localparam logic [7:0]  STACK_RESET       = 8'h00;
    localparam logic [7:0]  USB_ADDR_RESET    = 8'h00;
    localparam int          USB_ENABLE_BIT    = 7;
    localparam logic [13:0] RESET_VECTOR      = 14'h0000;

    // Clock and free-running timer
    localparam int          CLK_MHZ           = 25;
    localparam int          TICK_MHZ          = 1;
    localparam int          US_CYCLES         = CLK_MHZ / TICK_MHZ;
    localparam int          FRT_WIDTH         = 12;
    localparam int          WDT_TICK_BIT      = 11;
    localparam int          WDT_WIDTH         = 2;

    // Start-up and hold times
    localparam int          SHORT_DELAY_US    = 128;
    localparam int          LONG_DELAY_MS     = 96;
    localparam int          WDOG_HOLD_US      = 2048;
    localparam int          SHORT_DELAY_CYCLES = SHORT_DELAY_US * CLK_MHZ;
    localparam int          LONG_DELAY_CYCLES = LONG_DELAY_MS * 1000 * CLK_MHZ;
    localparam int          WDOG_HOLD_CYCLES  = WDOG_HOLD_US * CLK_MHZ;
    localparam int          DELAY_WIDTH       = 24;

    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_POR_CHECK,
        ST_SUSPEND,
        ST_START_DELAY,
        ST_WDOG_HOLD,
        ST_RUN
    } rwc_state_type;

    // One I/O access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       write;
        logic       read;
    } rwc_io_req_type;

    // USB line levels seen by the sequencer
    typedef struct packed {
        logic minusLine;
        logic plusLine;
        logic busReset;
    } rwc_usb_lines_type;

endpackage

// File: rwc_reset_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - Hardware reset restores registers, clears USB address, disables all interrupts.
// - Hardware reset loads program and data stack pointers with zero.
// - Status register 0xFF records POR bit 4, USB reset bit 5, watchdog bit 6.
// - After POR or watchdog reset fetch starts at zero, nothing pushed.
// - USB bus reset only sets its cause bit; it is no hardware reset.
// - POR sets power-on flag, forces ports to input; port 3 bit 7 steers.
// - Port 3 bit 7 high and idle lines after POR: suspend until activity.
// - Leaving suspend with port 3 bit 7 high runs 128 us hold.
// - Port 3 bit 7 low after POR runs 96 ms hold, then runs.
// - Delay: bit 7 high gives 128 us; else power-on flag gives 96 ms.
// - Watchdog reset when 2-bit counter MSB rises; sets status bit 6.
// - Watchdog counter advances on rising bit 11 of free-running timer.
// - Any write to port 0x26 clears the watchdog counter.
// - Watchdog reset holds 2.048 ms, then execution starts at zero.
// - USB transmitter stays off until firmware sets address MSB.
// - Free-running timer is 12 bits, incremented at 1 MHz.
module rwc_reset_ctrl #(
    parameter int LONG_DELAY_CYCLES = rwc_pkg::LONG_DELAY_CYCLES,
    parameter int WDOG_HOLD_CYCLES  = rwc_pkg::WDOG_HOLD_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // Core I/O access
    input  wire rwc_pkg::rwc_io_req_type   ioReq,
    output logic [7:0]                     ioRdData,
    // Core stack pointer loads
    input  wire logic                      progSpLoad,
    input  wire logic [7:0]                progSpLoadValue,
    input  wire logic                      dspLoad,
    input  wire logic [7:0]                dspLoadValue,
    // Pins sampled at start-up
    input  wire logic                      port3Bit7,
    input  wire rwc_pkg::rwc_usb_lines_type usbLines,
    // Core control
    output logic                           coreResetn,
    output logic                           resetEntry,
    output logic [13:0]                    fetchAddress,
    output logic                           interruptDisable,
    output logic [7:0]                     programStackPointer,
    output logic [7:0]                     dataStackPointer,
    // Port and USB control
    output logic                           gpioForceInput,
    output logic [7:0]                     usbDeviceAddress,
    output logic                           usbTransmitEnable,
    // Timer and watchdog visibility
    output logic [rwc_pkg::FRT_WIDTH-1:0]  freeRunTimer,
    output logic [rwc_pkg::WDT_WIDTH-1:0]  watchdogCount,
    output logic [7:0]                     statusControl
);

    // Counts above the delay counter or below one cycle cannot be served
    if (LONG_DELAY_CYCLES < 1 || LONG_DELAY_CYCLES >= (1 << rwc_pkg::DELAY_WIDTH) ||
        WDOG_HOLD_CYCLES < 1 || WDOG_HOLD_CYCLES >= (1 << rwc_pkg::DELAY_WIDTH) ||
        rwc_pkg::US_CYCLES < 2) begin : g_bad_params
        $error("rwc_reset_ctrl: delay parameters out of range");
    end

    rwc_pkg::rwc_state_type          state;
    logic [rwc_pkg::DELAY_WIDTH-1:0] delayCount;
    logic [7:0]                      prescale;
    logic                            tickBitPrev;
    logic                            wdtTick;
    logic                            watchdogFire;
    logic                            wdtClearWrite;
    logic                            hwReset;
    logic                            linesIdle;
    logic                            linesActive;

    // Start-up hold length from strap and power-on flag
    function automatic logic [rwc_pkg::DELAY_WIDTH-1:0] chooseDelay(
        input logic strap,
        input logic powerOnFlag
    );
        if (strap) begin
            chooseDelay = rwc_pkg::DELAY_WIDTH'(rwc_pkg::SHORT_DELAY_CYCLES);
        end else if (powerOnFlag) begin
            chooseDelay = rwc_pkg::DELAY_WIDTH'(LONG_DELAY_CYCLES);
        end else begin
            chooseDelay = rwc_pkg::DELAY_WIDTH'(rwc_pkg::SHORT_DELAY_CYCLES);
        end
    endfunction

    // Decode of core I/O accesses and line states
    assign wdtClearWrite = ioReq.write && (ioReq.addr == rwc_pkg::IO_WDT_CLEAR_ADDR);
    assign hwReset       = (state != rwc_pkg::ST_RUN);
    assign linesIdle     = usbLines.minusLine && !usbLines.plusLine;
    assign linesActive   = usbLines.busReset || !usbLines.minusLine;  // K or SE0
    assign watchdogFire  = wdtTick && (watchdogCount == 2'b01) && !wdtClearWrite;

    // Free-running timer, 1 MHz from a prescaler; never reset by the watchdog
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescale     <= 8'h00;
            freeRunTimer <= '0;
        end else if (prescale == 8'(rwc_pkg::US_CYCLES - 1)) begin
            prescale     <= 8'h00;
            freeRunTimer <= freeRunTimer + 12'h001;
        end else begin
            prescale     <= prescale + 8'h01;
        end
    end

    // Rising edge of the 4.096 ms timer bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tickBitPrev <= 1'b0;
            wdtTick     <= 1'b0;
        end else begin
            tickBitPrev <= freeRunTimer[rwc_pkg::WDT_TICK_BIT];
            wdtTick     <= freeRunTimer[rwc_pkg::WDT_TICK_BIT] && !tickBitPrev;
        end
    end

    // Watchdog counter; cleared at the fire edge too, else the tick would leave it at 2
    always_ff @(posedge clk) begin
        if (!resetn || hwReset || watchdogFire) begin
            watchdogCount <= '0;
        end else if (wdtClearWrite) begin
            watchdogCount <= '0;
        end else if (wdtTick) begin
            watchdogCount <= watchdogCount + 2'b01;
        end
    end

    // Reset sequencer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state      <= rwc_pkg::ST_POR_CHECK;
            delayCount <= '0;
        end else begin
            case (state)
                rwc_pkg::ST_POR_CHECK: begin
                    if (port3Bit7 && linesIdle) begin
                        state <= rwc_pkg::ST_SUSPEND;
                    end else begin
                        state      <= rwc_pkg::ST_START_DELAY;
                        delayCount <= chooseDelay(port3Bit7,
                            statusControl[rwc_pkg::STAT_POR_BIT]);
                    end
                end
                rwc_pkg::ST_SUSPEND: begin
                    // Bus activity ends the wait; the strap is re-read here
                    if (linesActive || usbLines.plusLine) begin
                        state      <= rwc_pkg::ST_START_DELAY;
                        delayCount <= chooseDelay(port3Bit7,
                            statusControl[rwc_pkg::STAT_POR_BIT]);
                    end
                end
                rwc_pkg::ST_START_DELAY, rwc_pkg::ST_WDOG_HOLD: begin
                    if (delayCount <= 24'h000001) begin
                        state <= rwc_pkg::ST_RUN;
                    end else begin
                        delayCount <= delayCount - 24'h000001;
                    end
                end
                rwc_pkg::ST_RUN: begin
                    if (watchdogFire) begin
                        state      <= rwc_pkg::ST_WDOG_HOLD;
                        delayCount <= rwc_pkg::DELAY_WIDTH'(WDOG_HOLD_CYCLES);
                    end
                end
                default: begin
                    state <= rwc_pkg::ST_POR_CHECK;
                end
            endcase
        end
    end

    // Core held in reset until the sequencer reaches run; entry is a jump, no push
    always_ff @(posedge clk) begin
        if (!resetn) begin
            coreResetn       <= 1'b0;
            resetEntry       <= 1'b0;
            fetchAddress     <= rwc_pkg::RESET_VECTOR;
            interruptDisable <= 1'b1;
        end else begin
            coreResetn       <= !hwReset && !watchdogFire;
            resetEntry       <= hwReset && (state != rwc_pkg::ST_POR_CHECK) &&
                                (state != rwc_pkg::ST_SUSPEND) &&
                                (delayCount <= 24'h000001);
            fetchAddress     <= rwc_pkg::RESET_VECTOR;
            interruptDisable <= hwReset || watchdogFire;
        end
    end

    // Ports stay inputs only while the power-on sequence runs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gpioForceInput <= 1'b1;
        end else begin
            gpioForceInput <= (state == rwc_pkg::ST_POR_CHECK) ||
                              (state == rwc_pkg::ST_SUSPEND) ||
                              (state == rwc_pkg::ST_START_DELAY);
        end
    end

    // Stack pointers, zeroed by every hardware reset from its first edge
    always_ff @(posedge clk) begin
        if (!resetn || hwReset || watchdogFire) begin
            programStackPointer <= rwc_pkg::STACK_RESET;
            dataStackPointer    <= rwc_pkg::STACK_RESET;
        end else begin
            if (progSpLoad) begin
                programStackPointer <= progSpLoadValue;
            end
            if (dspLoad) begin
                dataStackPointer <= dspLoadValue;
            end
        end
    end

    // USB address; the transmitter follows its top bit
    always_ff @(posedge clk) begin
        if (!resetn || hwReset || watchdogFire) begin
            usbDeviceAddress  <= rwc_pkg::USB_ADDR_RESET;
            usbTransmitEnable <= 1'b0;
        end else if (ioReq.write && ioReq.addr == rwc_pkg::IO_USB_ADDR_ADDR) begin
            usbDeviceAddress  <= ioReq.wrData;
            usbTransmitEnable <= ioReq.wrData[rwc_pkg::USB_ENABLE_BIT];
        end
    end

    // Status register; cause bits survive a watchdog reset, and a set beats a clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            statusControl <= rwc_pkg::STATUS_RESET;
            statusControl[rwc_pkg::STAT_POR_BIT] <= 1'b1;
        end else begin
            if (hwReset || watchdogFire) begin
                statusControl <= statusControl & rwc_pkg::CAUSE_MASK;
            end else if (ioReq.write && ioReq.addr == rwc_pkg::IO_STATUS_ADDR) begin
                statusControl <= ioReq.wrData;
            end
            if (watchdogFire) begin
                statusControl[rwc_pkg::STAT_WDOG_BIT] <= 1'b1;
            end
            if (usbLines.busReset && !hwReset) begin
                statusControl[rwc_pkg::STAT_USBR_BIT] <= 1'b1;
            end
        end
    end

    // Read data, registered one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ioRdData <= 8'h00;
        end else if (ioReq.read) begin
            if (ioReq.addr == rwc_pkg::IO_STATUS_ADDR) begin
                ioRdData <= statusControl;
            end else if (ioReq.addr == rwc_pkg::IO_USB_ADDR_ADDR) begin
                ioRdData <= usbDeviceAddress;
            end else begin
                ioRdData <= 8'h00;  // Clear port is write-only
            end
        end
    end

endmodule // rwc_reset_ctrl

// File: rwc_reset_ctrl_properties.sv
`timescale 1ns/1ns
module rwc_reset_ctrl_properties #(
    parameter int LONG_DELAY_CYCLES = rwc_pkg::LONG_DELAY_CYCLES,
    parameter int WDOG_HOLD_CYCLES  = rwc_pkg::WDOG_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       resetn,
    // Inputs from the core and the bus
    input wire rwc_pkg::rwc_io_req_type    ioReq,
    input wire rwc_pkg::rwc_usb_lines_type usbLines,
    // Outputs under watch
    input wire logic                       coreResetn,
    input wire logic                       resetEntry,
    input wire logic [13:0]                fetchAddress,
    input wire logic                       interruptDisable,
    input wire logic [7:0]                 programStackPointer,
    input wire logic [7:0]                 dataStackPointer,
    input wire logic                       gpioForceInput,
    input wire logic [7:0]                 usbDeviceAddress,
    input wire logic                       usbTransmitEnable,
    input wire logic [11:0]                freeRunTimer,
    input wire logic [1:0]                 watchdogCount,
    input wire logic [7:0]                 statusControl
);
    logic [7:0] gap;
    logic       seen;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Cycles since the timer last moved; first step skipped as prescaler phase is open
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gap  <= 8'h00;
            seen <= 1'h0;
        end else if ($changed(freeRunTimer)) begin
            gap  <= 8'h00;
            seen <= 1'h1;
        end else begin
            gap  <= gap + 8'h01;
        end
    end

    a_timer_rate: assert property (seen && $changed(freeRunTimer) |->
        gap == rwc_pkg::US_CYCLES - 1 && freeRunTimer == $past(freeRunTimer) + 12'h001)
        else $error("free-running timer step wrong");
    a_stack_cleared: assert property (!coreResetn && !resetEntry |->
        programStackPointer == 8'h00 && dataStackPointer == 8'h00)
        else $error("stack pointer not zero while core held");
    a_entry_release: assert property (resetEntry |-> fetchAddress == 14'h0000
        ##1 (!resetEntry && coreResetn && !interruptDisable))
        else $error("reset entry sequence wrong");
    a_wdt_fire: assert property ($fell(coreResetn) |-> statusControl[6]
        && watchdogCount == 2'h0 && usbDeviceAddress == 8'h00 && !usbTransmitEnable
        && interruptDisable) else $error("watchdog reset effects missing");
    a_wdog_held: assert property ($fell(coreResetn) |=> !coreResetn [*8])
        else $error("watchdog reset released too soon");
    a_wdt_clear: assert property (ioReq.write && ioReq.addr == 8'h26 |=>
        watchdogCount == 2'h0) else $error("watchdog not cleared by write");
    a_wdt_tick: assert property ($rose(watchdogCount[0]) |->
        freeRunTimer[11:1] == 11'h400) else $error("watchdog advanced off tick");
    a_bus_reset: assert property (usbLines.busReset && coreResetn |=>
        statusControl[5] && coreResetn) else $error("bus reset handling wrong");
    a_ports_input: assert property (gpioForceInput |-> !coreResetn)
        else $error("core running with ports forced to input");

    c_entry: cover property (resetEntry);
    c_wdt_fire: cover property ($fell(coreResetn));
    c_bus_reset: cover property (usbLines.busReset && coreResetn);
endmodule // rwc_reset_ctrl_properties

bind rwc_reset_ctrl rwc_reset_ctrl_properties #(
    .LONG_DELAY_CYCLES(LONG_DELAY_CYCLES), .WDOG_HOLD_CYCLES(WDOG_HOLD_CYCLES)
) u_props (
    .clk(clk), .resetn(resetn), .ioReq(ioReq), .usbLines(usbLines),
    .coreResetn(coreResetn), .resetEntry(resetEntry), .fetchAddress(fetchAddress),
    .interruptDisable(interruptDisable), .programStackPointer(programStackPointer),
    .dataStackPointer(dataStackPointer), .gpioForceInput(gpioForceInput),
    .usbDeviceAddress(usbDeviceAddress), .usbTransmitEnable(usbTransmitEnable),
    .freeRunTimer(freeRunTimer), .watchdogCount(watchdogCount), .statusControl(statusControl)
);

// File: rwc_reset_ctrl_tb.sv
`timescale 1ns/1ns
module rwc_reset_ctrl_tb;
    localparam int LONG_CYC = 50;
    localparam int HOLD_CYC = 40;
    // Stimulus, idle USB lines, observed outputs
    logic                       clk = 1'h0;
    logic                       resetn = 1'h0;
    rwc_pkg::rwc_io_req_type    ioReq = '0;
    rwc_pkg::rwc_usb_lines_type usbLines = 3'h4;
    logic                       progSpLoad = 1'h0;
    logic                       dspLoad = 1'h0;
    logic [7:0]                 progSpLoadValue = 8'h00;
    logic [7:0]                 dspLoadValue = 8'h00;
    logic                       port3Bit7 = 1'h0;
    logic [7:0]                 ioRdData, programStackPointer, dataStackPointer;
    logic [7:0]                 usbDeviceAddress, statusControl;
    logic [13:0]                fetchAddress;
    logic [11:0]                freeRunTimer;
    logic [1:0]                 watchdogCount;
    logic                       coreResetn, resetEntry, interruptDisable;
    logic                       gpioForceInput, usbTransmitEnable;
    int                         fails = 0;
    int                         total_checks = 0;
    int                         cycles = 0;
    // Address, written data, expected read back; FF 00 drops the power-on flag
    logic [23:0]                rows [4] = '{24'hFF7070, 24'hFF0000, 24'h265A00, 24'h403300};

    rwc_reset_ctrl #(.LONG_DELAY_CYCLES(LONG_CYC), .WDOG_HOLD_CYCLES(HOLD_CYC)) dut (
        .clk(clk), .resetn(resetn), .ioReq(ioReq), .ioRdData(ioRdData),
        .progSpLoad(progSpLoad), .progSpLoadValue(progSpLoadValue), .dspLoad(dspLoad),
        .dspLoadValue(dspLoadValue), .port3Bit7(port3Bit7), .usbLines(usbLines),
        .coreResetn(coreResetn), .resetEntry(resetEntry), .fetchAddress(fetchAddress),
        .interruptDisable(interruptDisable), .programStackPointer(programStackPointer),
        .dataStackPointer(dataStackPointer), .gpioForceInput(gpioForceInput),
        .usbDeviceAddress(usbDeviceAddress), .usbTransmitEnable(usbTransmitEnable),
        .freeRunTimer(freeRunTimer), .watchdogCount(watchdogCount), .statusControl(statusControl)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One strobe cycle, then a spare cycle so strobes never abut
    task automatic io(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        ioReq = '{addr: a, wrData: d, write: wr, read: rd};
        @(negedge clk);
        ioReq = '0;
        @(negedge clk);
    endtask

    task automatic do_reset(input logic strap);
        resetn = 1'h0;
        port3Bit7 = strap;
        repeat (3) @(negedge clk);
        check({statusControl, usbDeviceAddress, programStackPointer, dataStackPointer},
              32'h10000000);
        check({gpioForceInput, coreResetn, interruptDisable, watchdogCount}, 32'h14);
        resetn = 1'h1;
    endtask

    // Bounded wait for the core to be let go, delay judged against a window
    task automatic wait_core(input int lo, input int hi);
        int n;
        n = 0;
        while (coreResetn !== 1'h1 && n < hi + 10) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    // Hang guard, about a quarter above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 200000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        int n;
        do_reset(1'h0);
        wait_core(LONG_CYC, LONG_CYC + 4);
        check({gpioForceInput, interruptDisable, fetchAddress}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            io(1'h1, 1'h0, rows[i][23:16], rows[i][15:8]);
            io(1'h0, 1'h1, rows[i][23:16], 8'h00);
            check({24'h0, ioRdData}, {24'h0, rows[i][7:0]});
        end
        io(1'h1, 1'h0, rwc_pkg::IO_USB_ADDR_ADDR, 8'h85);
        check({usbDeviceAddress, usbTransmitEnable}, 32'h10B);
        // Firmware moves the data stack below the USB buffers
        {progSpLoad, progSpLoadValue, dspLoad, dspLoadValue} = {1'h1, 8'h3C, 1'h1, 8'hE0};
        @(negedge clk);
        {progSpLoad, dspLoad} = 2'h0;
        check({programStackPointer, dataStackPointer}, 32'h3CE0);
        usbLines.busReset = 1'h1;
        @(negedge clk);
        usbLines.busReset = 1'h0;
        check({statusControl, coreResetn}, 32'h41);
        // No clearing from here on, so the second tick must fire
        n = 0;
        while (coreResetn === 1'h1 && n < 160000) begin
            @(negedge clk);
            n++;
        end
        check({statusControl, watchdogCount, usbDeviceAddress, usbTransmitEnable}, 32'h30000);
        check({programStackPointer, dataStackPointer, freeRunTimer[11:4]}, 32'h80);
        wait_core(HOLD_CYC, HOLD_CYC + 4);
        do_reset(1'h1);
        repeat (4000) @(negedge clk);
        check({coreResetn, gpioForceInput}, 32'h1);
        usbLines.minusLine = 1'h0;
        wait_core(3200, 3204);
        print_verdict();
    end
endmodule // rwc_reset_ctrl_tb
